// ==== rtl/tws_pkg.sv ====
package tws_pkg;
	localparam int DEPTH        = 1024;
	localparam int PAGES        = 64;
	localparam int PAGE_BYTES   = 16;
	localparam int ADDR_W       = 10;
	localparam int PAGE_W       = 4;
	localparam logic [3:0] DEV_CODE = 4'hA;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [7:0] ERASED   = 8'hFF;
	// Write cycle time, microseconds, and clock rate in MHz
	localparam int T_WR_US      = 3000;
	localparam int CLK_MHZ      = 100;
	localparam int WR_CYCLES    = T_WR_US * CLK_MHZ;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEVADDR,
		ST_WORDADDR,
		ST_WRDATA,
		ST_RDDATA,
		ST_RDACK
	} tws_state_type;
endpackage

// ==== rtl/tws_slave.sv ====
`timescale 1ns/1ps
module tws_slave #(
	parameter int WR_CYCLES = tws_pkg::WR_CYCLES
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// Serial bus
	input  wire logic sclIn,
	input  wire logic sdaIn,
	output logic      sdaOut,
	output logic      sdaOe,
	// Straps
	input  wire logic chipSelectStrap,
	input  wire logic writeProtect,
	// Status
	output logic      standby_r,
	output logic      busy_r
);
	// Two-flop synchronisers, first stage read only by second
	logic [1:0] sclSync_r, sdaSync_r, csSync_r, wpSync_r;
	logic       sclD_r, sdaD_r;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sclSync_r <= 2'h3;
			sdaSync_r <= 2'h3;
			csSync_r  <= 2'h0;
			wpSync_r  <= 2'h0;
			sclD_r    <= 1'h1;
			sdaD_r    <= 1'h1;
		end else begin
			sclSync_r <= {sclSync_r[0], sclIn};
			sdaSync_r <= {sdaSync_r[0], sdaIn};
			csSync_r  <= {csSync_r[0], chipSelectStrap};
			wpSync_r  <= {wpSync_r[0], writeProtect};
			sclD_r    <= sclSync_r[1];
			sdaD_r    <= sdaSync_r[1];
		end
	end
	logic scl, sda, sclRise, sclFall, startCond, stopCond;
	assign scl       = sclSync_r[1];
	assign sda       = sdaSync_r[1];
	assign sclRise   = scl & ~sclD_r;
	assign sclFall   = ~scl & sclD_r;
	assign startCond = scl & sclD_r & sdaD_r & ~sda;
	assign stopCond  = scl & sclD_r & ~sdaD_r & sda;

	// Array of 64 pages x 16 bytes, plus page staging buffer
	// No reset on the array; it starts erased like a fresh part
	logic [7:0] mem [tws_pkg::DEPTH] = '{default: tws_pkg::ERASED};
	logic [7:0] pageBuf_r [tws_pkg::PAGE_BYTES];
	logic [tws_pkg::PAGE_BYTES-1:0] pageMask_r, pageMask_nxt;

	tws_pkg::tws_state_type state_r, state_nxt;
	logic [3:0]  bitCnt_r, bitCnt_nxt;
	logic [7:0]  shift_r, shift_nxt;
	logic [tws_pkg::ADDR_W-1:0] addr_r, addr_nxt;
	logic        ackPhase_r, ackPhase_nxt;
	logic        ackDrive_r, ackDrive_nxt;
	logic        sdaOut_nxt, sdaOe_nxt;
	logic        wasRead_r, wasRead_nxt;
	logic        standby_nxt, busy_nxt;
	logic [31:0] wrCnt_r, wrCnt_nxt;
	logic        bufWr;
	logic [tws_pkg::PAGE_W-1:0] bufIdx;
	logic        commit;

	always_comb begin
		state_nxt    = state_r;
		bitCnt_nxt   = bitCnt_r;
		shift_nxt    = shift_r;
		addr_nxt     = addr_r;
		ackPhase_nxt = ackPhase_r;
		ackDrive_nxt = ackDrive_r;
		sdaOut_nxt   = 1'h0;
		sdaOe_nxt    = sdaOe;
		wasRead_nxt  = wasRead_r;
		standby_nxt  = standby_r;
		busy_nxt     = busy_r;
		wrCnt_nxt    = wrCnt_r;
		pageMask_nxt = pageMask_r;
		bufWr        = 1'h0;
		bufIdx       = addr_r[tws_pkg::PAGE_W-1:0];
		commit       = 1'h0;
		// Programming outranks every bus event, so polls see no acknowledge
		if (busy_r) begin
			// Inputs ignored while programming
			sdaOe_nxt = 1'h0;
			state_nxt = tws_pkg::ST_IDLE;
			if (wrCnt_r == 32'(WR_CYCLES - 1)) begin
				busy_nxt    = 1'h0;
				standby_nxt = 1'h1;
				wrCnt_nxt   = 32'h0;
			end else begin
				wrCnt_nxt = wrCnt_r + 32'h1;
			end
		end else if (startCond) begin
			state_nxt    = tws_pkg::ST_DEVADDR;
			bitCnt_nxt   = 4'h0;
			ackPhase_nxt = 1'h0;
			sdaOe_nxt    = 1'h0;
			standby_nxt  = 1'h0;
			pageMask_nxt = '0;
		end else if (stopCond) begin
			state_nxt = tws_pkg::ST_IDLE;
			sdaOe_nxt = 1'h0;
			// Protected pages are dropped, never programmed
			if (|pageMask_r && !wpSync_r[1]) begin
				commit    = 1'h1;
				busy_nxt  = 1'h1;
				wrCnt_nxt = 32'h0;
			end else begin
				standby_nxt = 1'h1;
			end
			pageMask_nxt = '0;
		end else if (sclFall) begin
			// Output is driven only after falling clock; start, stop and programming release it at once
			if (ackPhase_r) begin
				sdaOe_nxt = ackDrive_r;
			end else if (state_r == tws_pkg::ST_RDDATA) begin
				sdaOe_nxt = ~shift_r[7];
			end else begin
				sdaOe_nxt = 1'h0;
			end
			if (ackPhase_r && bitCnt_r == 4'h9) begin
				ackPhase_nxt = 1'h0;
				bitCnt_nxt   = 4'h0;
				sdaOe_nxt    = (state_r == tws_pkg::ST_RDDATA) ? ~shift_r[7] : 1'h0;
				if (!ackDrive_r && state_r != tws_pkg::ST_RDDATA)
					state_nxt = tws_pkg::ST_IDLE;
			end
		end else if (sclRise && state_r != tws_pkg::ST_IDLE) begin
			if (ackPhase_r) begin
				bitCnt_nxt = 4'h9;
				if (state_r == tws_pkg::ST_RDACK) begin
					// Master ack continues the sequential read
					if (!sda) begin
						state_nxt = tws_pkg::ST_RDDATA;
						addr_nxt  = addr_r + 10'h1;
						shift_nxt = mem[addr_r + 10'h1];
					end else begin
						state_nxt = tws_pkg::ST_IDLE;
					end
				end
			end else begin
				shift_nxt  = {shift_r[6:0], sda};
				bitCnt_nxt = bitCnt_r + 4'h1;
				if (state_r == tws_pkg::ST_RDDATA)
					shift_nxt = {shift_r[6:0], 1'h1};
				if (bitCnt_r[2:0] == tws_pkg::BIT_LAST) begin
					ackPhase_nxt = 1'h1;
					ackDrive_nxt = 1'h1;
					case (state_r)
					tws_pkg::ST_DEVADDR: begin
						// Strap bit compared, other two are page bits
						if (shift_r[6:3] != tws_pkg::DEV_CODE ||
						    shift_r[2] != csSync_r[1]) begin
							ackDrive_nxt = 1'h0;
						end else if (sda) begin
							state_nxt   = tws_pkg::ST_RDDATA;
							wasRead_nxt = 1'h1;
							shift_nxt   = mem[addr_r];
						end else begin
							state_nxt   = tws_pkg::ST_WORDADDR;
							wasRead_nxt = 1'h0;
							addr_nxt    = {shift_r[1:0], addr_r[7:0]};
						end
					end
					tws_pkg::ST_WORDADDR: begin
						addr_nxt  = {addr_r[9:8], shift_r[6:0], sda};
						state_nxt = tws_pkg::ST_WRDATA;
					end
					tws_pkg::ST_WRDATA: begin
						bufWr  = 1'h1;
						pageMask_nxt[addr_r[3:0]] = 1'h1;
						addr_nxt = {addr_r[9:4], addr_r[3:0] + 4'h1};
					end
					tws_pkg::ST_RDDATA: begin
						ackDrive_nxt = 1'h0;
						state_nxt    = tws_pkg::ST_RDACK;
					end
					default: ;
					endcase
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r    <= tws_pkg::ST_IDLE;
			bitCnt_r   <= 4'h0;
			shift_r    <= 8'h0;
			addr_r     <= '0;
			ackPhase_r <= 1'h0;
			ackDrive_r <= 1'h0;
			sdaOut     <= 1'h0;
			sdaOe      <= 1'h0;
			wasRead_r  <= 1'h0;
			standby_r  <= 1'h1;
			busy_r     <= 1'h0;
			wrCnt_r    <= 32'h0;
			pageMask_r <= '0;
		end else begin
			state_r    <= state_nxt;
			bitCnt_r   <= bitCnt_nxt;
			shift_r    <= shift_nxt;
			addr_r     <= addr_nxt;
			ackPhase_r <= ackPhase_nxt;
			ackDrive_r <= ackDrive_nxt;
			sdaOut     <= sdaOut_nxt;
			sdaOe      <= sdaOe_nxt;
			wasRead_r  <= wasRead_nxt;
			standby_r  <= standby_nxt;
			busy_r     <= busy_nxt;
			wrCnt_r    <= wrCnt_nxt;
			pageMask_r <= pageMask_nxt;
		end
	end

	// Whole page lands in one cycle at the stop; unmasked bytes stay as they were
	always_ff @(posedge clk) begin
		if (bufWr)
			pageBuf_r[bufIdx] <= {shift_r[6:0], sda};
		if (commit) begin
			for (int j = 0; j < tws_pkg::PAGE_BYTES; j++)
				if (pageMask_r[j])
					mem[{addr_r[9:4], 4'(j)}] <= pageBuf_r[j];
		end
	end

	// All checks on the block clock; pins reach them only through the synchronisers
	AST_OPEN_DRAIN: assert property (@(posedge clk) disable iff (!rst_b)
		sdaOut == 1'h0) else $error("data line driven high");
	AST_BUSY_NO_DRIVE: assert property (@(posedge clk) disable iff (!rst_b)
		busy_r |-> ##1 !sdaOe) else $error("drive during programming");
	AST_WP_NO_PROG: assert property (@(posedge clk) disable iff (!rst_b)
		commit |-> !wpSync_r[1]) else $error("programming while protected");
	AST_STOP_PROG: assert property (@(posedge clk) disable iff (!rst_b)
		(stopCond && !busy_r && |pageMask_r && !wpSync_r[1]) |=> busy_r)
		else $error("no programming after stop");
	AST_STOP_STANDBY: assert property (@(posedge clk) disable iff (!rst_b)
		(stopCond && !busy_r && pageMask_r == '0) |=> standby_r)
		else $error("no standby after stop");
	AST_START_WAKE: assert property (@(posedge clk) disable iff (!rst_b)
		(startCond && !busy_r) |=> (state_r == tws_pkg::ST_DEVADDR && !standby_r))
		else $error("start not taken");
	AST_PROG_END: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(busy_r) |-> standby_r) else $error("no standby after programming");
	AST_OE_ON_FALL: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(sdaOe) |-> $past(sclFall)) else $error("output change off falling edge");
	AST_PAGE_WRAP: assert property (@(posedge clk) disable iff (!rst_b)
		bufWr |=> addr_r[9:4] == $past(addr_r[9:4])) else $error("page row moved");
	AST_READ_STOP: assert property (@(posedge clk) disable iff (!rst_b)
		(stopCond && !busy_r && wasRead_r) |=> standby_r)
		else $error("no standby after read");
	AST_BUSY_BOUND: assert property (@(posedge clk) disable iff (!rst_b)
		busy_r |-> wrCnt_r < 32'(WR_CYCLES))
		else $error("programming overran");
	AST_ACK_NINTH: assert property (@(posedge clk) disable iff (!rst_b)
		(sclFall && !busy_r && ackPhase_r && ackDrive_r && bitCnt_r == 4'h8) |=> sdaOe)
		else $error("no acknowledge on ninth clock");
	AST_STRAP_MISS: assert property (@(posedge clk) disable iff (!rst_b)
		(sclRise && !busy_r && state_r == tws_pkg::ST_DEVADDR && !ackPhase_r &&
		 bitCnt_r[2:0] == tws_pkg::BIT_LAST && shift_r[2] != csSync_r[1]) |=> !ackDrive_r)
		else $error("acknowledge for another strap");
	AST_PROTECT_ACK: assert property (@(posedge clk) disable iff (!rst_b)
		(sclRise && !busy_r && state_r == tws_pkg::ST_WRDATA && !ackPhase_r &&
		 bitCnt_r[2:0] == tws_pkg::BIT_LAST) |=> ackDrive_r)
		else $error("data byte not acknowledged");
	AST_IDLE_RELEASED: assert property (@(posedge clk) disable iff (!rst_b)
		state_r == tws_pkg::ST_IDLE |-> !sdaOe)
		else $error("line held while idle");
	COV_WRITE: cover property (@(posedge clk) disable iff (!rst_b) commit);
	COV_PROTECTED: cover property (@(posedge clk) disable iff (!rst_b)
		stopCond && |pageMask_r && wpSync_r[1]);
	COV_READ: cover property (@(posedge clk) disable iff (!rst_b)
		state_r == tws_pkg::ST_RDACK);
	COV_SEQ: cover property (@(posedge clk) disable iff (!rst_b)
		state_r == tws_pkg::ST_RDACK ##[1:200] state_r == tws_pkg::ST_RDDATA);
	COV_PROG_DONE: cover property (@(posedge clk) disable iff (!rst_b) $fell(busy_r));
endmodule

// ==== testbench/test_two_wire_eeprom_slave.sv ====
`timescale 1ns/1ps
module test_two_wire_eeprom_slave;
	localparam int WR = 200;
	logic       clk, rst_b, scl, pull, sda, sdaOut, sdaOe, strap, wp, standby_r, busy_r, ack;
	logic [7:0] exp [1024];
	int         miscompares, n_compared, cycles;
	assign sda = ~pull & ~(sdaOe & ~sdaOut);
	tws_slave #(.WR_CYCLES(WR)) tws_slave_i (.clk(clk), .rst_b(rst_b), .sclIn(scl),
		.sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .chipSelectStrap(strap),
		.writeProtect(wp), .standby_r(standby_r), .busy_r(busy_r));
	tws_master tws_master_i (.clk(clk), .scl(scl), .pull(pull), .line(sda));
	task automatic check(input logic [7:0] seen, input logic [7:0] want, input string m);
		n_compared++;
		if (seen !== want) begin
			miscompares++;
			$display("mismatch at %0t: %s seen %h want %h", $time, m, seen, want);
		end
	endtask
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr(input logic [9:0] a, input int n, input logic [7:0] b, input logic fin);
		tws_master_i.start();
		tws_master_i.sendByte({tws_pkg::DEV_CODE, strap, a[9:8], 1'b0}, ack);
		check(8'(ack), 8'h01, "dev ack");
		tws_master_i.sendByte(a[7:0], ack);
		check(8'(ack), 8'h01, "addr ack");
		for (int i = 0; i < n; i++) begin
			tws_master_i.sendByte(b + 8'(i), ack);
			check(8'(ack), 8'h01, "data ack");
			if (!wp)
				exp[{a[9:4], a[3:0] + 4'(i)}] = b + 8'(i);
		end
		if (fin)
			tws_master_i.stop();
	endtask
	task automatic settle(input logic prog);
		int k;
		k = 0;
		repeat (6) @(negedge clk);
		check(8'(busy_r), 8'(prog), "busy");
		while (busy_r === 1'b1 && k < WR + 10) begin
			@(negedge clk);
			k++;
		end
		check(8'(k <= WR), 8'h01, "write time");
		repeat (2) @(negedge clk);
		check(8'(standby_r), 8'h01, "standby");
	endtask
	task automatic rd(input logic [9:0] a, input int n);
		logic [7:0] d;
		wr(a, 0, 8'h00, 1'b0);
		tws_master_i.start();
		tws_master_i.sendByte({tws_pkg::DEV_CODE, strap, a[9:8], 1'b1}, ack);
		check(8'(ack), 8'h01, "read ack");
		for (int i = 0; i < n; i++) begin
			tws_master_i.readByte(i == n - 1, d);
			check(d, exp[a + 10'(i)], "read data");
		end
		tws_master_i.stop();
		settle(1'b0);
	endtask
	task automatic t_byte();
		wr(10'h3FF, 1, 8'h5A, 1'b1);
		tws_master_i.start();
		tws_master_i.sendByte({tws_pkg::DEV_CODE, strap, 3'h6}, ack);
		check(8'(ack), 8'h00, "poll ack");
		tws_master_i.stop();
		settle(1'b1);
		rd(10'h3FF, 2);
		$display("test byte done");
	endtask
	task automatic t_page();
		wr(10'h05F, 17, 8'h10, 1'b1);
		settle(1'b1);
		rd(10'h050, 17);
		wr(10'h123, 2, 8'hC0, 1'b1);
		settle(1'b1);
		rd(10'h120, 8);
		$display("test page done");
	endtask
	task automatic t_guard();
		wp = 1'b1;
		wr(10'h051, 1, 8'h77, 1'b1);
		settle(1'b0);
		wp = 1'b0;
		rd(10'h051, 1);
		tws_master_i.start();
		tws_master_i.sendByte({tws_pkg::DEV_CODE, ~strap, 3'h0}, ack);
		check(8'(ack), 8'h00, "strap ack");
		tws_master_i.stop();
		strap = 1'b0;
		rd(10'h3FF, 1);
		$display("test guard done");
	endtask
	// Abort mid-read while the slave may hold the line low
	task automatic t_recover();
		logic r;
		wr(10'h050, 0, 8'h00, 1'b0);
		tws_master_i.start();
		tws_master_i.sendByte({tws_pkg::DEV_CODE, strap, 3'h1}, ack);
		check(8'(ack), 8'h01, "abort ack");
		repeat (3) tws_master_i.bitx(1'b1, r);
		check(8'(r), 8'(exp[10'h050][5]), "abort bit");
		tws_master_i.recover(r);
		check(8'(r), 8'h01, "recover high");
		tws_master_i.stop();
		rd(10'h050, 1);
		$display("test recover done");
	endtask
	always @(negedge clk)
		if (rst_b && sdaOe !== 1'b0)
			check(8'(sdaOut), 8'h00, "driven high");
	always @(posedge clk) begin
		cycles++;
		if (cycles == 80000) begin
			miscompares++;
			conclude();
		end
	end
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		rst_b = 1'b0;
		strap = 1'b1;
		wp = 1'b0;
		foreach (exp[i])
			exp[i] = tws_pkg::ERASED;
		repeat (16) @(negedge clk);
		rst_b = 1'b1;
		repeat (4) @(negedge clk);
		check(8'(standby_r), 8'h01, "power-up");
		t_byte();
		t_page();
		t_guard();
		t_recover();
		conclude();
	end
endmodule

// ==== testbench/tws_master.sv ====
`timescale 1ns/1ps
module tws_master (
	// Clock
	input  wire logic clk,
	// Bus
	output logic      scl,
	output logic      pull,
	input  wire logic line
);
	initial begin
		scl = 1'b1;
		pull = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Bit of 80 ns: 40 ns low with data set early, 40 ns high, line read mid-high
	task automatic bitx(input logic b, output logic r);
		tick(1);
		pull = ~b;
		tick(3);
		scl = 1'b1;
		tick(2);
		r = line;
		tick(2);
		scl = 1'b0;
	endtask
	task automatic start();
		tick(1);
		pull = 1'b0;
		tick(3);
		scl = 1'b1;
		tick(4);
		pull = 1'b1;
		tick(4);
		scl = 1'b0;
	endtask
	task automatic stop();
		tick(1);
		pull = 1'b1;
		tick(3);
		scl = 1'b1;
		tick(4);
		pull = 1'b0;
		tick(4);
	endtask
	task automatic sendByte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(b[i], r);
		bitx(1'b1, r);
		ack = ~r;
	endtask
	task automatic readByte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(1'b1, d[i]);
		bitx(last, r);
	endtask
	// Start made while the clock is still high, before the slave can drive again
	task automatic recover(output logic seen);
		seen = 1'b0;
		for (int i = 0; i < 9 && seen !== 1'b1; i++) begin
			tick(1);
			pull = 1'b0;
			tick(3);
			scl = 1'b1;
			tick(2);
			seen = line;
			if (seen === 1'b1)
				pull = 1'b1;
			tick(2);
			scl = 1'b0;
		end
	endtask
endmodule
